// ### common/pfcfg_pkg.sv
/*
 * constants for the synthesizer function configuration block.
 * assumes a byte-wide register write/read port inside the device.
 */
package pfcfg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_GATE_FMT = 8'h17;
    localparam logic [7:0] ADDR_LOOP_BW = 8'h1e;
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int BIT_OUT_UNLOCK_EN = 4;
    localparam int BIT_RATIO_FMT = 3;
    localparam int BW_LSB = 4;
    localparam int BW_W = 3;
    localparam logic [7:0] MASK_GATE_FMT = 8'h18;
    localparam logic [7:0] MASK_LOOP_BW = 8'h70;
    localparam logic [7:0] RESET_GATE_FMT = 8'h00;
    localparam logic [7:0] RESET_LOOP_BW = 8'h00;
    // ------------------------------------------------------------
    // ratio formats
    // ------------------------------------------------------------
    localparam logic FMT_20_12 = 1'b0;
    localparam logic FMT_12_20 = 1'b1;
    localparam logic SRC_STATIC = 1'b0;
    localparam logic SRC_DYNAMIC = 1'b1;
    localparam int FRAC_BITS_HI = 20;
    localparam int FRAC_BITS_LO = 12;
    localparam int RATIO_W = 32;
endpackage

// ### core/pfcfg_bw_latch.sv
/*
 * holds the minimum loop bandwidth code applied to the loop; it takes a new
 * code only while the loop is unlocked, so a change made while locked
 * waits until the loop next drops out of lock.
 * assumes lock status is synchronous to CLK.
 */
`timescale 1ns/1ps
module pfcfg_bw_latch (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // code in and lock state
    input wire logic [2:0] code_in,
    input wire logic locked,
    // applied code
    output logic [2:0] code_out
);
    typedef struct packed {
        logic [2:0] code_r;
    } pfcfg_bwl_t;
    pfcfg_bwl_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        if (!locked) begin
            s_nxt.code_r = code_in;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end
    assign code_out = s_r.code_r;
endmodule // pfcfg_bw_latch

// ### core/pfcfg_regs.sv
/*
 * function configuration registers of the synthesizer: output gating on
 * unlock, user ratio format and minimum loop bandwidth selection.
 * assumes the serial control port delivers one-cycle byte write strobes
 * and a combinational read address, all synchronous to CLK.
 */
`timescale 1ns/1ps
module pfcfg_regs (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // register port
    input wire logic WR_EN,
    input wire logic [7:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic [7:0] RD_ADDR,
    output logic [7:0] RD_DATA,
    // pll status and mode
    input wire logic PLL_LOCKED,
    input wire logic FRACN_SOURCE_SEL,
    input wire logic DEVICE_CONFIG_ENABLE,
    input wire logic [31:0] USER_RATIO_VALUE,
    // clock output path
    input wire logic PLL_CLK_RAW,
    output logic CLK_OUT,
    // ratio and loop settings to the synthesizer
    output logic [31:0] RATIO_INT_PART,
    output logic [31:0] RATIO_FRAC_PART,
    output logic [4:0] RATIO_FRAC_BITS,
    output logic HYBRID_MODE,
    output logic [2:0] INPUT_MIN_LOOP_BW,
    output logic [7:0] MIN_LOOP_BW_HZ
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic output_on_unlock_en;
        logic low_freq_ratio_format;
        logic [2:0] input_min_loop_bw;
        logic [7:0] rd_data;
        logic [31:0] int_part;
        logic [31:0] frac_part;
        logic [4:0] frac_bits;
        logic hybrid;
        logic [7:0] bw_hz;
    } pfcfg_st_t;
    pfcfg_st_t s_r, s_nxt;
    logic [2:0] bw_applied;
    logic gate_fmt_hit, loop_bw_hit, fmt_eff;
    // ------------------------------------------------------------
    // applied bandwidth
    // ------------------------------------------------------------
    pfcfg_bw_latch u_bw (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .code_in(s_r.input_min_loop_bw),
        .locked(PLL_LOCKED & DEVICE_CONFIG_ENABLE),
        .code_out(bw_applied)
    );
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    assign gate_fmt_hit = WR_EN && (WR_ADDR == pfcfg_pkg::ADDR_GATE_FMT);
    assign loop_bw_hit = WR_EN && (WR_ADDR == pfcfg_pkg::ADDR_LOOP_BW);
    // static mode forces 12.20 whatever the format bit says
    assign fmt_eff = (FRACN_SOURCE_SEL == pfcfg_pkg::SRC_DYNAMIC) ?
        s_r.low_freq_ratio_format : pfcfg_pkg::FMT_12_20;
    always_comb begin
        s_nxt = s_r;
        if (gate_fmt_hit) begin
            s_nxt.output_on_unlock_en = WR_DATA[pfcfg_pkg::BIT_OUT_UNLOCK_EN];
            s_nxt.low_freq_ratio_format = WR_DATA[pfcfg_pkg::BIT_RATIO_FMT];
        end
        if (loop_bw_hit) begin
            s_nxt.input_min_loop_bw = WR_DATA[pfcfg_pkg::BW_LSB +: pfcfg_pkg::BW_W];
        end
        case (RD_ADDR)
            pfcfg_pkg::ADDR_GATE_FMT: begin
                s_nxt.rd_data = 8'h00;
                s_nxt.rd_data[pfcfg_pkg::BIT_OUT_UNLOCK_EN] = s_r.output_on_unlock_en;
                s_nxt.rd_data[pfcfg_pkg::BIT_RATIO_FMT] = s_r.low_freq_ratio_format;
            end
            pfcfg_pkg::ADDR_LOOP_BW: begin
                s_nxt.rd_data = 8'h00;
                s_nxt.rd_data[pfcfg_pkg::BW_LSB +: pfcfg_pkg::BW_W] = s_r.input_min_loop_bw;
            end
            default: begin
                s_nxt.rd_data = 8'h00;
            end
        endcase
        s_nxt.hybrid = FRACN_SOURCE_SEL;
        if (fmt_eff == pfcfg_pkg::FMT_20_12) begin
            s_nxt.frac_bits = 5'(pfcfg_pkg::FRAC_BITS_LO);
            s_nxt.int_part = USER_RATIO_VALUE >> pfcfg_pkg::FRAC_BITS_LO;
            s_nxt.frac_part = USER_RATIO_VALUE & 32'h00000fff;
        end else begin
            s_nxt.frac_bits = 5'(pfcfg_pkg::FRAC_BITS_HI);
            s_nxt.int_part = USER_RATIO_VALUE >> pfcfg_pkg::FRAC_BITS_HI;
            s_nxt.frac_part = USER_RATIO_VALUE & 32'h000fffff;
        end
        s_nxt.bw_hz = 8'h01 << bw_applied;
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r <= '0;
            s_r.output_on_unlock_en <= pfcfg_pkg::RESET_GATE_FMT[pfcfg_pkg::BIT_OUT_UNLOCK_EN];
            s_r.low_freq_ratio_format <= pfcfg_pkg::RESET_GATE_FMT[pfcfg_pkg::BIT_RATIO_FMT];
            s_r.input_min_loop_bw <= pfcfg_pkg::RESET_LOOP_BW[pfcfg_pkg::BW_LSB +: pfcfg_pkg::BW_W];
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // gating is combinational so, with output_on_unlock_en clear, the output drops with the unlock report
    assign CLK_OUT = PLL_CLK_RAW & (PLL_LOCKED | s_r.output_on_unlock_en);
    assign RD_DATA = s_r.rd_data;
    assign RATIO_INT_PART = s_r.int_part;
    assign RATIO_FRAC_PART = s_r.frac_part;
    assign RATIO_FRAC_BITS = s_r.frac_bits;
    assign HYBRID_MODE = s_r.hybrid;
    assign INPUT_MIN_LOOP_BW = bw_applied;
    assign MIN_LOOP_BW_HZ = s_r.bw_hz;
endmodule // pfcfg_regs

// ### tb/pfcfg_host_model.sv
/* host side: writes one configuration byte per strobe.
   assumes clk comes from the bench. */
`timescale 1ns/1ps
module pfcfg_host_model (
    // clock
    input wire logic clk,
    // byte write port
    output logic wr_en = 1'b0,
    output logic [7:0] wr_addr = 8'h00,
    output logic [7:0] wr_data = 8'h00
);
    // idle lines show the inverse of the last byte
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask
endmodule // pfcfg_host_model

// ### tb/pfcfg_regs_monitor.sv
/* port assertions for pfcfg_regs.
   assumes it is bound to the design top and that writes and reads follow CLK. */
`timescale 1ns/1ps
module pfcfg_regs_monitor (
    // watched ports
    input wire logic CLK, RST, CE, WR_EN, PLL_LOCKED, FRACN_SOURCE_SEL, DEVICE_CONFIG_ENABLE,
    input wire logic PLL_CLK_RAW, CLK_OUT, HYBRID_MODE,
    input wire logic [7:0] WR_ADDR, WR_DATA, RD_ADDR, RD_DATA, MIN_LOOP_BW_HZ,
    input wire logic [31:0] USER_RATIO_VALUE, RATIO_INT_PART,
    input wire logic [4:0] RATIO_FRAC_BITS,
    input wire logic [2:0] INPUT_MIN_LOOP_BW
);
    // mirror of enable, format and bandwidth fields
    logic [4:0] m_r;
    wire logic wa = CE && WR_EN && WR_ADDR == 8'h17;
    wire logic wb = CE && WR_EN && WR_ADDR == 8'h1e;
    wire logic lk = PLL_LOCKED && DEVICE_CONFIG_ENABLE;
    wire logic [2:0] bw_m = m_r[2:0];
    wire logic [7:0] rd_m = RD_ADDR == 8'h17 ? {3'h0, m_r[4:3], 3'h0} :
        RD_ADDR == 8'h1e ? {1'h0, bw_m, 4'h0} : 8'h00;
    always_ff @(posedge CLK or posedge RST)
        if (RST) m_r <= 5'h00;
        else m_r <= {wa ? WR_DATA[4:3] : m_r[4:3], wb ? WR_DATA[6:4] : bw_m};
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (RST);
    a_gate_low: assert property (!PLL_LOCKED && !m_r[4] |-> !CLK_OUT)
        else $error("output not gated");
    a_no_gate: assert property (PLL_LOCKED || m_r[4] |-> CLK_OUT == PLL_CLK_RAW)
        else $error("output gated");
    a_fmt_hi_mult: assert property (CE && FRACN_SOURCE_SEL && !m_r[3] |=>
        RATIO_FRAC_BITS == 5'h0c && RATIO_INT_PART == $past(USER_RATIO_VALUE) >> 12)
        else $error("wide integer split");
    a_static_fmt: assert property (CE && !FRACN_SOURCE_SEL |=>
        RATIO_FRAC_BITS == 5'h14 && !HYBRID_MODE) else $error("static format");
    a_bw_decode: assert property (CE |=>
        MIN_LOOP_BW_HZ == 8'h01 << $past(INPUT_MIN_LOOP_BW)) else $error("bandwidth decode");
    a_bw_hold: assert property (CE && lk |=> $stable(INPUT_MIN_LOOP_BW))
        else $error("bandwidth changed while locked");
    a_bw_apply: assert property (CE && !lk |=> INPUT_MIN_LOOP_BW == $past(bw_m))
        else $error("bandwidth not applied");
    a_read_back: assert property (CE |=> RD_DATA == $past(rd_m))
        else $error("read data");
    c_hybrid: cover property (CE && FRACN_SOURCE_SEL && m_r[3]);
    c_frozen: cover property (lk && bw_m != INPUT_MIN_LOOP_BW);
    c_gated: cover property (!PLL_LOCKED && !m_r[4] && PLL_CLK_RAW);
endmodule // pfcfg_regs_monitor

// ### tb/test_pfcfg_regs.sv
/* bench top: host model writes bytes, an integer model predicts every result.
   assumes package, design, host model and checker are compiled first. */
`timescale 1ns/1ps
module test_pfcfg_regs;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, lock = 1'b0, sel = 1'b0, dce = 1'b0, raw = 1'b0;
    logic [7:0] rd_addr = 8'h00, wr_addr, wr_data, rd_data, hz;
    logic [31:0] ratio = 32'h00000000, r_int, r_frac;
    logic [4:0] r_bits;
    logic [2:0] code;
    logic wr_en, clk_out, hyb;
    int n_mismatch = 0, cmp_count = 0, en = 0, fmt = 0, bw = 0, fb;
    int exp_q[$];
    pfcfg_host_model i_pfcfg_host_model (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data));
    pfcfg_regs i_pfcfg_regs (.CLK(clk), .RST(rst), .CE(ce), .WR_EN(wr_en), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .PLL_LOCKED(lock),
        .FRACN_SOURCE_SEL(sel), .DEVICE_CONFIG_ENABLE(dce), .USER_RATIO_VALUE(ratio),
        .PLL_CLK_RAW(raw), .CLK_OUT(clk_out), .RATIO_INT_PART(r_int), .RATIO_FRAC_PART(r_frac),
        .RATIO_FRAC_BITS(r_bits), .HYBRID_MODE(hyb), .INPUT_MIN_LOOP_BW(code),
        .MIN_LOOP_BW_HZ(hz));
    task automatic chk(input logic [31:0] got, input int exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_pfcfg_host_model.put(a, d);
        if (a == 8'h17) en = d[4];
        if (a == 8'h17) fmt = d[3];
        if (a == 8'h1e) bw = d[6:4];
    endtask
    task automatic rd(input logic [7:0] a);
        exp_q.push_back(a == 8'h17 ? en * 16 + fmt * 8 : a == 8'h1e ? bw * 16 : 0);
        @(posedge clk);
        rd_addr <= a;
        wt(1);
        chk(32'(rd_data), exp_q.pop_front());
    endtask
    initial forever #50 clk = ~clk;
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(32'h5b75f9d5));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'h17);
        wr(8'h20, 8'hff);
        rd(8'h20);
        for (int c = 0; c < 8; c++) begin
            wr(8'h1e, 8'h8f | 8'(c << 4));
            wt(2);
            chk(32'(code), bw);
            chk(32'(hz), 1 << c);
            rd(8'h1e);
        end
        wr(8'h1e, 8'h30);
        @(posedge clk);
        {dce, lock} <= 2'b11;
        wr(8'h1e, 8'h50);
        wt(3);
        chk(32'(code), 3);
        @(posedge clk);
        lock <= 1'b0;
        wt(1);
        chk(32'(code), bw);
        for (int e = 0; e < 2; e++) begin
            wr(8'h17, e ? 8'hff : 8'he7);
            rd(8'h17);
            repeat (12) begin
                @(posedge clk);
                {lock, raw} <= 2'($urandom);
                @(negedge clk);
                chk(32'(clk_out), raw & (lock | en));
            end
        end
        for (int m = 0; m < 4; m++) begin
            wr(8'h17, {4'h0, m[0], 3'h0});
            @(posedge clk);
            sel <= m[1];
            ratio <= m == 2 ? 32'h32000000 : m == 3 ? 32'h0013a92a : $urandom;
            wt(1);
            fb = sel && !fmt ? 12 : 20;
            chk(32'(r_bits), fb);
            chk(r_int, ratio >> fb);
            chk(r_frac, ratio & ((1 << fb) - 1));
            chk(32'(hyb), m[1]);
        end
        // a write made while the clock enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        i_pfcfg_host_model.put(8'h1e, 8'h70);
        @(posedge clk);
        ce <= 1'b1;
        rd(8'h1e);
        final_report();
    end
endmodule // test_pfcfg_regs
bind pfcfg_regs pfcfg_regs_monitor i_pfcfg_regs_monitor (.*);
